// ---- shared/scp_defs.svh ----
// Purpose: constants of the serial control port: map, field positions, resets, timing
// Assumes: included by bare name; definitions only
// Notes:   lengths are data-phase lengths in bits
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// ==========================================================
// register map (five-bit address)
`define SCP_NREG        6
`define SCP_A_CTRL      5'h00
`define SCP_A_CFR2      5'h01
`define SCP_A_ASF       5'h02
`define SCP_A_RAMP      5'h03
`define SCP_A_FTW       5'h04
`define SCP_A_POW       5'h05

// ==========================================================
// data-phase lengths in bits
`define SCP_L_CTRL      6'h20
`define SCP_L_CFR2      6'h18
`define SCP_L_ASF       6'h10
`define SCP_L_RAMP      6'h08
`define SCP_L_FTW       6'h20
`define SCP_L_POW       6'h10
`define SCP_L_NONE      6'h08

// ==========================================================
// fields, resets, timing
`define SCP_B_LSB       8
`define SCP_B_SEP       9
`define SCP_INSTR_LAST  5'h07
`define SCP_REG_RST     32'h0000_0000
`define SCP_SYNC_LAST   2'h3

`endif

// ---- shared/scp_pkg.sv ----
// Purpose: types of the serial control port
// Assumes: nothing
// Notes:   constants live in scp_defs.svh
package scp_pkg;
   // ==========================================================
   // cycle phase
   typedef enum logic {
      SCP_INSTR = 1'b0,
      SCP_DATA  = 1'b1
   } scp_st_t;

   typedef logic [31:0] scp_word_t;
   typedef logic [4:0]  scp_addr_t;
endpackage : scp_pkg

// ---- shared/scp_upd_if.sv ----
// Purpose: update timing link between port core and update timer
// Assumes: both ends on mclk
// Notes:   commit is a one-cycle pulse
`timescale 1ns/1ps
interface scp_upd_if;
   logic commit;
   logic pending;

   modport upd  (output commit, output pending);
   modport port (input  commit, input  pending);
endinterface : scp_upd_if

// ---- core/scp_update.sv ----
// Purpose: sync-clock tick, update pin sampling and buffer commit timing
// Assumes: sync clock is the core clock divided by four
// Notes:   a level held over several ticks commits again, which is harmless
`timescale 1ns/1ps
`include "scp_defs.svh"
module scp_update (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   // update pin
   input  wire logic io_update,
   // timing link
   scp_upd_if.upd    u
);
   logic [1:0] div_q;
   logic       upd_meta_q;
   logic       upd_s_q;
   logic       pend_q;
   logic       tick;

   // ==========================================================
   // sync clock as a tick of the core clock
   assign tick = (div_q == `SCP_SYNC_LAST);

   always_ff @(posedge mclk) begin
      if (rst) begin
         div_q <= 2'h0;
      end else if (ce) begin
         div_q <= div_q + 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         upd_meta_q <= 1'b0;
         upd_s_q    <= 1'b0;
      end else if (ce) begin
         upd_meta_q <= io_update;
         upd_s_q    <= upd_meta_q;
      end
   end

   // ==========================================================
   // level seen on one tick commits on the next
   always_ff @(posedge mclk) begin
      if (rst) begin
         pend_q <= 1'b0;
      end else if (ce && tick) begin
         pend_q <= upd_s_q;
      end
   end

   assign u.commit  = ce & tick & pend_q;
   assign u.pending = pend_q;

   // ==========================================================
   // checks
   sequence s_upd_seen;
      tick && upd_s_q && ce;
   endsequence

   a_commit_delay : assert property (@(posedge mclk) disable iff (rst)
      s_upd_seen ##1 ce [*4] |-> u.commit)
      else $error("update not committed one sync cycle after detection");
endmodule : scp_update

// ---- core/scp_port.sv ----
// Purpose: serial control port with double-buffered registers
// Assumes: serial pins asynchronous to mclk; sclk well below mclk/4
// Notes:   registers are copied from buffers only by the update timer
`timescale 1ns/1ps
`include "scp_defs.svh"

// Functional notes
// - a cycle is an eight-bit instruction on rising sclk, then data bytes
// - data length follows the addressed register, e.g. 24 or 32 bits
// - after the last data bit the next eight rising edges form an instruction
// - each written data bit enters the buffer on a rising sclk edge
// - read data bits are driven on falling sclk edges
// - reads return the active registers, never the buffers
// - instruction bit 7 high means read, low means write
// - instruction bits 6 and 5 are ignored
// - instruction bits 4 to 0 address the register
// - update level is sampled on sync clock edges and commits all buffers
// - the copy lands one sync clock after the update was seen
// - select high puts both data outputs in high impedance
// - select high mid-cycle freezes progress until select returns low
// - control bit 9 picks line setup; writes always enter on the data line
// - in single-line setup the separate output never drives
// - abort cancels the cycle, keeps registers, next cycle starts fresh
// - control bit 8 selects lsb-first for instruction and data
// - lsb-first keeps phase order and shifts register low bit to high
// - registers are double-buffered and change only on update
module scp_port (
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   // serial pins
   input  wire logic                   sclk,
   input  wire logic                   cs_n,
   input  wire logic                   sdio_i,
   output logic                        sdio_o,
   output logic                        sdio_oe,
   output logic                        serial_data_out,
   output logic                        serial_data_out_oe,
   // control pins
   input  wire logic                   port_abort,
   input  wire logic                   io_update,
   // active registers and status
   output logic [`SCP_NREG*32-1:0]     active_regs,
   output logic                        busy,
   output logic                        update_pending
);
   // ==========================================================
   // pin synchronisers
   logic [3:0]       pin_raw;
   logic [3:0]       meta_q;
   logic [3:0]       pin_q;
   logic             sclk_last_q;
   logic             sclk_s;
   logic             cs_s;
   logic             din_s;
   logic             abort_s;
   logic             rise;
   logic             fall;

   assign pin_raw = {port_abort, sdio_i, cs_n, sclk};

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q      <= 4'h0;
         pin_q       <= 4'h0;
         sclk_last_q <= 1'b0;
      end else if (ce) begin
         meta_q      <= pin_raw;
         pin_q       <= meta_q;
         sclk_last_q <= pin_q[0];
      end
   end

   assign sclk_s  = pin_q[0];
   assign cs_s    = pin_q[1];
   assign din_s   = pin_q[2];
   assign abort_s = pin_q[3];
   assign rise    = sclk_s & ~sclk_last_q;
   assign fall    = ~sclk_s & sclk_last_q;

   // ==========================================================
   // register storage: buffers and active copies
   scp_pkg::scp_word_t buf_q [`SCP_NREG];
   scp_pkg::scp_word_t act_q [`SCP_NREG];
   logic               lsb;
   logic               sep;

   assign lsb = act_q[0][`SCP_B_LSB];
   assign sep = act_q[0][`SCP_B_SEP];

   // ==========================================================
   // cycle state
   scp_pkg::scp_st_t st_q;
   logic [4:0]       cnt_q;
   logic [7:0]       instr_q;
   logic [7:0]       instr_nx;
   scp_pkg::scp_addr_t addr_nx;
   logic             rd_q;
   logic             hit_q;
   logic [2:0]       idx_q;
   logic [5:0]       nbits_q;
   logic [5:0]       pos6;
   logic [4:0]       pos;
   logic             go;
   logic             last_bit;

   function automatic logic [5:0] len_of(input scp_pkg::scp_addr_t a);
      unique case (a)
         `SCP_A_CTRL: len_of = `SCP_L_CTRL;
         `SCP_A_CFR2: len_of = `SCP_L_CFR2;
         `SCP_A_ASF:  len_of = `SCP_L_ASF;
         `SCP_A_RAMP: len_of = `SCP_L_RAMP;
         `SCP_A_FTW:  len_of = `SCP_L_FTW;
         `SCP_A_POW:  len_of = `SCP_L_POW;
         default:     len_of = `SCP_L_NONE;
      endcase
   endfunction : len_of

   // shift order of the instruction follows the bit-order setting
   assign instr_nx = lsb ? {din_s, instr_q[7:1]} : {instr_q[6:0], din_s};
   assign addr_nx  = instr_nx[4:0];

   // bit position inside the register for the current data bit
   assign pos6 = lsb ? {1'b0, cnt_q}
                     : nbits_q - 6'h01 - {1'b0, cnt_q};
   assign pos  = pos6[4:0];

   // select high or abort stops all progress
   assign go       = ce & ~abort_s & ~cs_s & rise;
   assign last_bit = ({1'b0, cnt_q} == nbits_q - 6'h01);

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q    <= scp_pkg::SCP_INSTR;
         cnt_q   <= 5'h00;
         instr_q <= 8'h00;
      end else if (ce && abort_s) begin
         st_q    <= scp_pkg::SCP_INSTR;
         cnt_q   <= 5'h00;
         instr_q <= 8'h00;
      end else if (go) begin
         unique case (st_q)
            scp_pkg::SCP_INSTR: begin
               instr_q <= instr_nx;
               if (cnt_q == `SCP_INSTR_LAST) begin
                  st_q  <= scp_pkg::SCP_DATA;
                  cnt_q <= 5'h00;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            scp_pkg::SCP_DATA: begin
               if (last_bit) begin
                  st_q  <= scp_pkg::SCP_INSTR;
                  cnt_q <= 5'h00;
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
         endcase
      end
   end

   // decoded instruction, held for the data phase
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_q    <= 1'b0;
         hit_q   <= 1'b0;
         idx_q   <= 3'h0;
         nbits_q <= `SCP_L_NONE;
      end else if (ce && abort_s) begin
         rd_q    <= 1'b0;
      end else if (go && st_q == scp_pkg::SCP_INSTR && cnt_q == `SCP_INSTR_LAST) begin
         rd_q    <= instr_nx[7];
         hit_q   <= (addr_nx < 5'(`SCP_NREG));
         idx_q   <= addr_nx[2:0];
         nbits_q <= len_of(addr_nx);
      end
   end

   assign busy = (st_q == scp_pkg::SCP_DATA) | (cnt_q != 5'h00);

   // ==========================================================
   // write path into the buffers
   logic wr_bit;

   assign wr_bit = go & (st_q == scp_pkg::SCP_DATA) & ~rd_q & hit_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < `SCP_NREG; i++) begin
            buf_q[i] <= `SCP_REG_RST;
         end
      end else if (wr_bit) begin
         buf_q[idx_q][pos] <= din_s;
      end
   end

   // ==========================================================
   // update commit: buffers to active registers
   scp_upd_if upd_link ();

   scp_update u_update (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .io_update (io_update),
      .u         (upd_link.upd)
   );

   assign update_pending = upd_link.pending;

   // only the commit pulse moves data; a partial write stays invisible
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < `SCP_NREG; i++) begin
            act_q[i] <= `SCP_REG_RST;
         end
      end else if (upd_link.commit) begin
         for (int i = 0; i < `SCP_NREG; i++) begin
            act_q[i] <= buf_q[i];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `SCP_NREG; g++) begin : g_act
         assign active_regs[g*32 +: 32] = act_q[g];
      end
   endgenerate

   // ==========================================================
   // read path
   logic dout_q;
   logic rd_fall;
   logic rd_bit;
   logic rd_on;

   assign rd_fall = ce & ~abort_s & ~cs_s & fall & (st_q == scp_pkg::SCP_DATA) & rd_q;
   assign rd_bit  = hit_q ? act_q[idx_q][pos] : 1'b0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         dout_q <= 1'b0;
      end else if (rd_fall) begin
         dout_q <= rd_bit;
      end
   end

   // enables follow select; reads go to one line only
   assign rd_on              = ~cs_s & rd_q & (st_q == scp_pkg::SCP_DATA);
   assign sdio_oe            = rd_on & ~sep;
   assign serial_data_out_oe = rd_on & sep;
   assign sdio_o             = dout_q;
   assign serial_data_out    = dout_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_instr_done;
      go && st_q == scp_pkg::SCP_INSTR && cnt_q == `SCP_INSTR_LAST;
   endsequence

   sequence s_data_done;
      go && st_q == scp_pkg::SCP_DATA && last_bit;
   endsequence

   a_instr_len : assert property (
      s_instr_done |=> st_q == scp_pkg::SCP_DATA && cnt_q == 5'h00)
      else $error("instruction phase did not end after eight bits");

   a_addr_len : assert property (
      s_instr_done |=> nbits_q == len_of($past(addr_nx)))
      else $error("data length does not match address");

   a_dir_bit : assert property (
      s_instr_done |=> rd_q == $past(instr_nx[7]))
      else $error("direction not taken from instruction bit 7");

   a_data_end : assert property (
      s_data_done |=> st_q == scp_pkg::SCP_INSTR && cnt_q == 5'h00)
      else $error("data phase did not return to instruction");

   a_instr_range : assert property (
      st_q == scp_pkg::SCP_INSTR |-> cnt_q <= `SCP_INSTR_LAST)
      else $error("instruction bit count out of range");

   a_data_range : assert property (
      st_q == scp_pkg::SCP_DATA |-> {1'b0, cnt_q} < nbits_q)
      else $error("data bit count beyond register length");

   a_msb_start : assert property (
      s_instr_done ##1 !lsb |-> pos6 == nbits_q - 6'h01)
      else $error("msb-first data does not start at the top bit");

   a_lsb_start : assert property (
      s_instr_done ##1 lsb |-> pos6 == 6'h00)
      else $error("lsb-first data does not start at bit zero");

   a_abort_clear : assert property (
      ce && abort_s |=> st_q == scp_pkg::SCP_INSTR && cnt_q == 5'h00 && !rd_q)
      else $error("abort did not restart the cycle");

   a_cs_freeze : assert property (
      ce && cs_s && !abort_s |=> $stable(st_q) && $stable(cnt_q) && $stable(instr_q))
      else $error("cycle moved while deselected");

   a_cs_hiz : assert property (
      cs_s |-> !sdio_oe && !serial_data_out_oe)
      else $error("output enabled while deselected");

   a_single_line : assert property (
      !sep |-> !serial_data_out_oe)
      else $error("separate output driven in single-line setup");

   a_sep_line : assert property (
      rd_on && sep |-> serial_data_out_oe && !sdio_oe)
      else $error("separate line setup drove the wrong line");

   a_read_keeps_buf : assert property (
      rd_q |=> buf_q[0] == $past(buf_q[0]) && buf_q[5] == $past(buf_q[5]))
      else $error("buffer changed during a read");

   a_commit_copy : assert property (
      upd_link.commit |=> act_q[1] == $past(buf_q[1]) && act_q[5] == $past(buf_q[5]))
      else $error("commit did not copy the buffers");

   a_write_bit : assert property (
      wr_bit |=> buf_q[$past(idx_q)][$past(pos)] == $past(din_s))
      else $error("written bit not stored in buffer");

   a_read_bit : assert property (
      rd_fall |=> dout_q == $past(rd_bit))
      else $error("read bit not driven from active register");

   a_act_hold : assert property (
      !upd_link.commit |=> act_q[0] == $past(act_q[0]) && act_q[4] == $past(act_q[4]))
      else $error("active register changed without update");
endmodule : scp_port

// ---- bench/scp_host.sv ----
// Purpose: host controller model driving the serial control lines
// Assumes: called from the bench at rising mclk; writes at 160 ns sclk
// Notes:   reads run at 1 us per bit; sclk stands low outside frames
`timescale 1ns/1ps
module scp_host (
   // clock
   input  wire logic mclk,
   // device outputs
   input  wire logic sdio_o,
   input  wire logic sdio_oe,
   input  wire logic serial_data_out,
   input  wire logic serial_data_out_oe,
   // serial lines
   output logic      sclk,
   output logic      cs_n,
   output wire logic sdio_i,
   output logic      port_abort
);
   logic h_q;
   logic lsb;
   logic sd_seen;
   logic so_seen;
   logic susp_oe;
   int   hp;

   // shared line: device wins while it drives
   assign sdio_i = sdio_oe ? sdio_o : h_q;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      port_abort = 1'b0;
      h_q = 1'b0;
      lsb = 1'b0;
      hp = 4;
   end

   always @(posedge mclk) begin
      if (sdio_oe) sd_seen = 1'b1;
      if (serial_data_out_oe) so_seen = 1'b1;
   end

   // ==========================================================
   // frame and bit tasks
   task automatic open_f(input bit slow);
      hp = slow ? 25 : 4;
      sd_seen = 1'b0;
      so_seen = 1'b0;
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : open_f

   task automatic bit_x(input logic b, output logic r);
      sclk <= 1'b0;
      h_q  <= b;
      repeat (hp) @(posedge mclk);
      // sample before the rise: the last bit's enable drops right after it
      r = serial_data_out_oe ? serial_data_out : (sdio_oe ? sdio_i : ~h_q);
      sclk <= 1'b1;
      repeat (hp) @(posedge mclk);
   endtask : bit_x

   // order follows the device's bit order setting
   task automatic shift(input logic [31:0] v, input int n, output logic [31:0] r);
      int   idx;
      logic b;
      r = 32'h0000_0000;
      for (int i = 0; i < n; i++) begin
         idx = lsb ? i : n - 1 - i;
         bit_x(v[idx], b);
         r[idx] = b;
      end
   endtask : shift

   // spurious sclk edges while deselected must be ignored
   task automatic suspend();
      cs_n <= 1'b1;
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      susp_oe = sdio_oe | serial_data_out_oe;
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : suspend

   task automatic abort_f();
      port_abort <= 1'b1;
      repeat (6) @(posedge mclk);
      port_abort <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : abort_f

   task automatic close_f();
      sclk <= 1'b0;
      repeat (hp) @(posedge mclk);
      cs_n <= 1'b1;
      h_q  <= ~h_q;
      repeat (4) @(posedge mclk);
   endtask : close_f
endmodule : scp_host

// ---- bench/tb.sv ----
// Purpose: self-checking bench of the serial control port
// Assumes: mclk 50 MHz, synchronous active-high reset
// Notes:   expected words follow from the written values and the update rules
`timescale 1ns/1ps
`include "scp_defs.svh"
module tb;
   logic                    mclk = 1'b0;
   logic                    rst = 1'b1;
   logic                    ce = 1'b1;
   logic                    io_update = 1'b0;
   logic                    sclk, cs_n, sdio_i, port_abort;
   logic                    sdio_o, sdio_oe, serial_data_out, serial_data_out_oe;
   logic [`SCP_NREG*32-1:0] active_regs;
   logic                    busy, update_pending;
   logic [31:0]             r, r2;
   int                      n_mismatch = 0;
   int                      checks = 0;
   int                      cyc = 0;

   always #10 mclk = ~mclk;

   scp_port u_dut (.mclk(mclk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
      .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
      .port_abort(port_abort), .io_update(io_update), .active_regs(active_regs),
      .busy(busy), .update_pending(update_pending));

   scp_host u_host (.mclk(mclk), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
      .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
      .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .port_abort(port_abort));

   // ==========================================================
   // helpers
   function automatic logic [31:0] word(input int i);
      return active_regs[i*32 +: 32];
   endfunction : word

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // held over one sync period, so timing against the tick is loose
   task automatic upd();
      @(posedge mclk);
      io_update <= 1'b1;
      repeat (6) @(posedge mclk);
      io_update <= 1'b0;
      @(negedge mclk);
      chk("update pending", update_pending, 32'h0000_0001);
      repeat (14) @(posedge mclk);
      chk("update settled", update_pending, 32'h0000_0000);
   endtask : upd

   task automatic wr(input logic [7:0] ins, input logic [31:0] v, input int n);
      u_host.open_f(1'b0);
      u_host.shift(ins, 8, r2);
      u_host.shift(v, n, r2);
      u_host.close_f();
   endtask : wr

   task automatic rd(input logic [7:0] ins, input int n, output logic [31:0] v);
      u_host.open_f(1'b1);
      u_host.shift(ins, 8, r2);
      u_host.shift(32'h0000_0000, n, v);
      u_host.close_f();
   endtask : rd

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // ==========================================================
   // scenarios
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("ctrl reset", word(0), 32'h0000_0000);
      // buffered write stays hidden until update
      wr(8'h05, 32'h0000_0800, 16);
      rd(8'h85, 16, r);
      chk("read before update", r, 32'h0000_0000);
      chk("pow before update", word(5), 32'h0000_0000);
      upd();
      chk("pow after update", word(5), 32'h0000_0800);
      // read suspended mid data phase
      u_host.open_f(1'b1);
      u_host.shift(8'h85, 8, r2);
      u_host.shift(32'h0000_0000, 8, r);
      u_host.suspend();
      u_host.shift(32'h0000_0000, 8, r2);
      u_host.close_f();
      chk("suspended read", {r[7:0], r2[7:0]}, 32'h0000_0800);
      chk("oe while deselected", u_host.susp_oe, 32'h0000_0000);
      chk("data line drove", u_host.sd_seen, 32'h0000_0001);
      chk("separate line idle", u_host.so_seen, 32'h0000_0000);
      // back to back, ignored bits set, then unmapped and abort
      u_host.open_f(1'b0);
      u_host.shift(8'h61, 8, r2);
      u_host.shift(32'h00A5_5A3C, 24, r2);
      u_host.shift(8'h04, 8, r2);
      u_host.shift(32'h1234_5678, 32, r2);
      u_host.shift(8'h07, 8, r2);
      u_host.shift(32'h0000_00FF, 8, r2);
      u_host.shift(8'h03, 8, r2);
      u_host.shift(32'h0000_000F, 4, r2);
      chk("busy mid cycle", busy, 32'h0000_0001);
      u_host.abort_f();
      chk("busy after abort", busy, 32'h0000_0000);
      chk("ramp after abort", word(3), 32'h0000_0000);
      u_host.shift(8'h03, 8, r2);
      u_host.shift(32'h0000_005C, 8, r2);
      u_host.close_f();
      upd();
      chk("cfr2 word", word(1), 32'h00A5_5A3C);
      chk("ftw word", word(4), 32'h1234_5678);
      chk("ramp word", word(3), 32'h0000_005C);
      // clock enable low freezes the update path
      wr(8'h03, 32'h0000_0033, 8);
      ce <= 1'b0;
      io_update <= 1'b1;
      repeat (12) @(posedge mclk);
      io_update <= 1'b0;
      repeat (4) @(posedge mclk);
      ce <= 1'b1;
      repeat (12) @(posedge mclk);
      chk("ramp frozen", word(3), 32'h0000_005C);
      upd();
      chk("ramp after thaw", word(3), 32'h0000_0033);
      // lsb first with the separate output line
      wr(8'h00, 32'h0000_0300, 32);
      upd();
      u_host.lsb = 1'b1;
      rd(8'h84, 32, r);
      chk("lsb read ftw", r, 32'h1234_5678);
      chk("data line quiet", u_host.sd_seen, 32'h0000_0000);
      chk("separate line drove", u_host.so_seen, 32'h0000_0001);
      wr(8'h05, 32'h0000_BEEF, 16);
      upd();
      chk("lsb write pow", word(5), 32'h0000_BEEF);
      wrap_up();
   end
endmodule : tb
